//--- src/cmo_pkg.sv
// Constants and types for one comparator output channel.
// Assumes a 100 MHz system clock and an APB master with 32-bit data.

package cmo_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] MAIN_CTRL_ADDR = 8'h00;
  localparam logic [7:0] EDGE_EN_ADDR = 8'h04;
  localparam logic [7:0] EVENT_ADDR = 8'h08;
  localparam logic [7:0] MIRROR_ADDR = 8'h0C;

  // ==========================================================================
  // main control, edge enable and event fields
  localparam int ENABLE_BIT = 7;
  localparam int RESULT_BIT = 6;
  localparam int SPEED_BIT = 5;
  localparam int INVERT_BIT = 4;
  localparam int FILTER_BIT = 3;
  localparam int RESERVED_BIT = 2;
  localparam int BAND_BIT = 1;
  localparam int SYNC_BIT = 0;
  localparam int RISE_EN_BIT = 1;
  localparam int FALL_EN_BIT = 0;
  localparam int FLAG_BIT = 0;
  localparam logic RESERVED_RESET = 1'b1;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_HOLD_NS = 20;
  localparam int FILTER_HOLD_CYC = (FILTER_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic enable;
    logic speedPowerSelect;
    logic invertOutputSelect;
    logic glitchHoldFilterEnable;
    logic reservedOne;
    logic inputBandEnable;
    logic syncSelect;
  } cmo_ctrl_t;

  typedef struct packed {
    logic coreEnable;
    logic inputsConnect;
    logic speedPowerSelect;
    logic inputBandEnable;
    logic routeOpampToInverting;
  } cmo_analog_t;

endpackage

//--- src/cmo_hold_filter.sv
// Anti-oscillation hold filter on the comparator output.
// Assumes the input is already on the system clock.
`timescale 1ns/1ps
module cmo_hold_filter (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic filterEnable,
  input wire logic din,
  output logic dout
);

  logic held;
  logic [3:0] holdCount;

  // the filtered path lags din by one clock, then stands for the hold count
  assign dout = filterEnable ? held : din;

  always_ff @(posedge clk) begin
    if (rst) begin
      held <= 1'b0;
      holdCount <= 4'h0;
    end else if (!filterEnable) begin
      held <= din;
      holdCount <= 4'h0;
    end else if (holdCount != 4'h0) begin
      holdCount <= holdCount - 4'h1;
    end else if (din != held) begin
      held <= din;
      holdCount <= 4'(cmo_pkg::FILTER_HOLD_CYC - 1);
    end
  end

endmodule

//--- src/cmo_edge_detect.sv
// Rising and falling edge detector on a registered level.
// Assumes the input is on the system clock.
`timescale 1ns/1ps
module cmo_edge_detect (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in, pulses out
  input wire logic din,
  output logic rise,
  output logic fall
);

  logic prev;

  assign rise = din & ~prev;
  assign fall = ~din & prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= din;
    end
  end

endmodule

//--- src/cmo_channel.sv
// One comparator output channel: polarity, hold filter, timer sync latch,
// edge event flag and the APB register slave.
// Assumes the analog result and the timer clock are asynchronous pins.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module cmo_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog core
  input wire logic compareRaw,
  input wire logic invertingSharesOpamp,
  input wire logic opampEnabled,
  output cmo_pkg::cmo_analog_t analogCtrl,
  // gate timer
  input wire logic timerClkDivided,
  output logic timerAdvance,
  output logic gateTimerCompare,
  // pin and peers
  output logic pinOut,
  input wire logic [4:0] peerResults,
  // event
  output logic comparatorEventFlag
);

  // ==========================================================================
  // registers
  cmo_pkg::cmo_ctrl_t ctrl;
  logic riseFlagEnable;
  logic fallFlagEnable;
  logic [31:0] next_prdata;
  logic rawMeta;
  logic rawSync;
  logic tclkMeta;
  logic tclkSync;
  logic tclkPrev;
  logic syncLatch;
  logic resultBit;

  // ==========================================================================
  // bus decode
  wire setupPhase = psel & ~penable;
  wire accessWrite = psel & penable & pwrite;
  wire hitMain = paddr == cmo_pkg::MAIN_CTRL_ADDR;
  wire hitEdge = paddr == cmo_pkg::EDGE_EN_ADDR;
  wire hitEvent = paddr == cmo_pkg::EVENT_ADDR;
  wire hitMirror = paddr == cmo_pkg::MIRROR_ADDR;
  wire hitAny = hitMain | hitEdge | hitEvent | hitMirror;
  wire wrMain = accessWrite & hitMain;
  wire wrEdge = accessWrite & hitEdge;
  wire clearFlag = accessWrite & hitEvent & pwdata[cmo_pkg::FLAG_BIT];

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hitAny;

  // ==========================================================================
  // output path
  wire enabledResult = ctrl.enable & rawSync;
  wire polarResult = enabledResult ^ ctrl.invertOutputSelect;
  logic compareOut;

  cmo_hold_filter u_filter (
    .clk(clk),
    .rst(rst),
    .filterEnable(ctrl.glitchHoldFilterEnable),
    .din(polarResult),
    .dout(compareOut)
  );

  // timer clock edges, seen only after the two-stage synchroniser
  wire timerFall = tclkPrev & ~tclkSync;
  wire timerRise = ~tclkPrev & tclkSync;
  assign timerAdvance = timerRise;

  // sync off leaves the pin path unlatched on purpose (lowest latency)
  assign gateTimerCompare = ctrl.syncSelect ? syncLatch : compareOut;
  assign pinOut = gateTimerCompare;

  // ==========================================================================
  // edges and event flag
  logic resultRise;
  logic resultFall;

  cmo_edge_detect u_edges (
    .clk(clk),
    .rst(rst),
    .din(resultBit),
    .rise(resultRise),
    .fall(resultFall)
  );

  wire setEvent = (resultRise & riseFlagEnable) | (resultFall & fallFlagEnable);

  // ==========================================================================
  // analog controls
  assign analogCtrl.coreEnable = ctrl.enable;
  assign analogCtrl.inputsConnect = ctrl.enable;
  assign analogCtrl.speedPowerSelect = ctrl.speedPowerSelect;
  assign analogCtrl.inputBandEnable = ctrl.inputBandEnable;
  assign analogCtrl.routeOpampToInverting = invertingSharesOpamp & opampEnabled;

  // ==========================================================================
  // read data
  wire [7:0] mainRead = {ctrl.enable, resultBit, ctrl.speedPowerSelect,
    ctrl.invertOutputSelect, ctrl.glitchHoldFilterEnable, ctrl.reservedOne,
    ctrl.inputBandEnable, ctrl.syncSelect};
  wire [7:0] edgeRead = {6'h00, riseFlagEnable, fallFlagEnable};
  wire [7:0] mirrorRead = {2'h0, peerResults, resultBit};

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hitMain) begin
      next_prdata = {24'h00_0000, mainRead};
    end else if (hitEdge) begin
      next_prdata = {24'h00_0000, edgeRead};
    end else if (hitEvent) begin
      next_prdata = {31'h0000_0000, comparatorEventFlag};
    end else if (hitMirror) begin
      next_prdata = {24'h00_0000, mirrorRead};
    end
  end

  // ==========================================================================
  // synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      rawMeta <= 1'b0;
      rawSync <= 1'b0;
      tclkMeta <= 1'b0;
      tclkSync <= 1'b0;
      tclkPrev <= 1'b0;
    end else begin
      rawMeta <= compareRaw;
      rawSync <= rawMeta;
      tclkMeta <= timerClkDivided;
      tclkSync <= tclkMeta;
      tclkPrev <= tclkSync;
    end
  end

  // ==========================================================================
  // result, latch and flag
  always_ff @(posedge clk) begin
    if (rst) begin
      resultBit <= 1'b0;
      syncLatch <= 1'b0;
      comparatorEventFlag <= 1'b0;
    end else begin
      resultBit <= compareOut;
      if (timerFall) begin
        syncLatch <= compareOut;
      end
      // set beats a clear in the same cycle
      if (setEvent) begin
        comparatorEventFlag <= 1'b1;
      end else if (clearFlag) begin
        comparatorEventFlag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= '{default: 1'b0, reservedOne: cmo_pkg::RESERVED_RESET};
      riseFlagEnable <= 1'b0;
      fallFlagEnable <= 1'b0;
    end else begin
      if (wrMain) begin
        ctrl.enable <= pwdata[cmo_pkg::ENABLE_BIT];
        ctrl.speedPowerSelect <= pwdata[cmo_pkg::SPEED_BIT];
        ctrl.invertOutputSelect <= pwdata[cmo_pkg::INVERT_BIT];
        ctrl.glitchHoldFilterEnable <= pwdata[cmo_pkg::FILTER_BIT];
        ctrl.reservedOne <= pwdata[cmo_pkg::RESERVED_BIT];
        ctrl.inputBandEnable <= pwdata[cmo_pkg::BAND_BIT];
        ctrl.syncSelect <= pwdata[cmo_pkg::SYNC_BIT];
      end
      if (wrEdge) begin
        riseFlagEnable <= pwdata[cmo_pkg::RISE_EN_BIT];
        fallFlagEnable <= pwdata[cmo_pkg::FALL_EN_BIT];
      end
    end
  end

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sync_latch;
    timerFall && ctrl.syncSelect && !wrMain |=> gateTimerCompare == $past(compareOut);
  endproperty
  a_sync_latch: assert property (p_sync_latch) else $error("sync latch missed timer fall");

  property p_async_pass;
    !ctrl.syncSelect |-> pinOut == compareOut && gateTimerCompare == compareOut;
  endproperty
  a_async_pass: assert property (p_async_pass) else $error("async path not direct");

  property p_edges_apart;
    timerAdvance |-> !timerFall ##1 $stable(syncLatch);
  endproperty
  a_edges_apart: assert property (p_edges_apart) else $error("advance and latch collide");

  property p_rise_sets;
    resultRise && riseFlagEnable |=> comparatorEventFlag;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise did not set flag");

  property p_set_wins;
    setEvent && clearFlag |=> comparatorEventFlag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge");

  property p_disabled_off;
    !ctrl.enable |-> !analogCtrl.coreEnable && !analogCtrl.inputsConnect && !enabledResult;
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("disabled core still active");

  property p_invert_event;
    !ctrl.enable && !ctrl.glitchHoldFilterEnable && riseFlagEnable && fallFlagEnable && $stable(ctrl.enable)
      && $changed(ctrl.invertOutputSelect) && !wrEdge ##1 !wrEdge |=> comparatorEventFlag;
  endproperty
  a_invert_event: assert property (p_invert_event) else $error("invert toggle gave no event");

  property p_hold;
    ctrl.glitchHoldFilterEnable && $past(ctrl.glitchHoldFilterEnable) && $changed(compareOut)
      ##1 ctrl.glitchHoldFilterEnable |-> $stable(compareOut);
  endproperty
  a_hold: assert property (p_hold) else $error("filter let output reverse early");

  property p_mirror;
    mirrorRead[0] == resultBit && mainRead[cmo_pkg::RESULT_BIT] == resultBit;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror differs from result");

  // ==========================================================================
  // flag, detector, timer, analog control and register checks, and covers

  property p_fall_sets;
    resultFall && fallFlagEnable |=> comparatorEventFlag;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall did not set flag");

  property p_no_stray_set;
    !comparatorEventFlag && !setEvent |=> !comparatorEventFlag;
  endproperty
  a_no_stray_set: assert property (p_no_stray_set) else $error("flag set with no enabled edge");

  property p_clear;
    clearFlag && !setEvent |=> !comparatorEventFlag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear write left flag set");

  property p_sticky;
    comparatorEventFlag && !clearFlag |=> comparatorEventFlag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a clear");

  property p_result_reg;
    resultBit == $past(compareOut);
  endproperty
  a_result_reg: assert property (p_result_reg) else $error("result bit not registered output");

  property p_advance_pulse;
    timerAdvance |=> !timerAdvance;
  endproperty
  a_advance_pulse: assert property (p_advance_pulse) else $error("timer advance longer than a cycle");

  property p_latch_on_fall;
    !timerFall |=> $stable(syncLatch);
  endproperty
  a_latch_on_fall: assert property (p_latch_on_fall) else $error("sync latch moved off a timer fall");

  property p_sync_out_holds;
    ctrl.syncSelect && !timerFall && !wrMain |=> $stable(gateTimerCompare);
  endproperty
  a_sync_out_holds: assert property (p_sync_out_holds) else $error("synced output moved between falls");

  property p_rise_detect;
    resultRise == $rose(resultBit);
  endproperty
  a_rise_detect: assert property (p_rise_detect) else $error("rise detector wrong");

  property p_fall_detect;
    resultFall == $fell(resultBit);
  endproperty
  a_fall_detect: assert property (p_fall_detect) else $error("fall detector wrong");

  property p_speed_out;
    analogCtrl.speedPowerSelect == ctrl.speedPowerSelect;
  endproperty
  a_speed_out: assert property (p_speed_out) else $error("speed select not driven");

  property p_band_out;
    analogCtrl.inputBandEnable == ctrl.inputBandEnable;
  endproperty
  a_band_out: assert property (p_band_out) else $error("band enable not driven");

  property p_route;
    analogCtrl.routeOpampToInverting == (invertingSharesOpamp && opampEnabled);
  endproperty
  a_route: assert property (p_route) else $error("op-amp routing wrong");

  property p_inputs_open;
    analogCtrl.inputsConnect == ctrl.enable;
  endproperty
  a_inputs_open: assert property (p_inputs_open) else $error("inputs connected while disabled");

  property p_mirror_peers;
    mirrorRead[5:1] == peerResults;
  endproperty
  a_mirror_peers: assert property (p_mirror_peers) else $error("mirror peers out of order");

  property p_read_capture;
    setupPhase |=> prdata == $past(next_prdata);
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read data not taken in setup");

  property p_unmapped;
    psel && penable && !hitAny |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  c_event: cover property (setEvent && clearFlag);
  c_sync: cover property (ctrl.syncSelect && timerFall && $changed(compareOut));
  c_filter: cover property (ctrl.glitchHoldFilterEnable && $changed(compareOut));
  c_fall_event: cover property (resultFall && fallFlagEnable);
  c_advance: cover property (timerAdvance && ctrl.syncSelect);

endmodule

//--- bench/cmo_far_model.sv
// Far side of one channel: analog compare core and gate timer clock.
// Assumes the bench sets the wanted compare level and whether the timer runs.
`timescale 1ns/1ps
module cmo_far_model (
  // clock
  input wire logic clk,
  // control from bench and channel
  input wire logic coreOn,
  input wire logic level,
  input wire logic timerRun,
  // to channel
  output logic compareRaw,
  output logic timerClk
);
  logic junk = 1'b0;
  logic tclkQ = 1'b0;
  logic [1:0] div = 2'h0;
  assign timerClk = tclkQ;
  // an unpowered core has no valid level, so show a pattern that keeps moving
  assign compareRaw = coreOn ? level : junk;
  // divided clock stands still while the timer is stopped
  always @(posedge clk) begin
    junk <= ~junk;
    if (timerRun) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
        tclkQ <= ~tclkQ;
      end
    end
  end
endmodule

//--- bench/tb_cmo_channel.sv
// Self-checking bench for one comparator output channel.
// Assumes the far-side model in cmo_far_model.sv.
`timescale 1ns/1ps
module tb_cmo_channel;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, raw, tclk, tAdv, gate, pinOut, flag, prevClk;
  logic level = 1'b0;
  logic timerRun = 1'b0;
  logic shares = 1'b0;
  logic opampOn = 1'b0;
  cmo_pkg::cmo_analog_t analogCtrl;
  int errors = 0;
  int n_compared = 0;
  int hi, rises, adv;

  always #5 clk = ~clk;

  cmo_channel u_cmo_channel (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compareRaw(raw), .invertingSharesOpamp(shares), .opampEnabled(opampOn), .analogCtrl(analogCtrl),
    .timerClkDivided(tclk), .timerAdvance(tAdv), .gateTimerCompare(gate), .pinOut(pinOut),
    .peerResults(5'h15), .comparatorEventFlag(flag));
  cmo_far_model u_cmo_far_model (.clk(clk), .coreOn(analogCtrl.coreEnable), .level(level),
    .timerRun(timerRun), .compareRaw(raw), .timerClk(tclk));

  // ==========================================================================
  // tasks
  task automatic tally_and_finish;
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50) begin
      errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never drives psel twice in a time step
    @(posedge clk);
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg%h", a), exp, rd);
    chk("pslverr", 32'(e), 32'(err));
  endtask

  // ==========================================================================
  // sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("analogCtrl", 32'h0, 32'(analogCtrl));
    rchk(cmo_pkg::MAIN_CTRL_ADDR, 32'h04, 1'b0);
    rchk(cmo_pkg::EDGE_EN_ADDR, 32'h00, 1'b0);
    rchk(cmo_pkg::EVENT_ADDR, 32'h00, 1'b0);
    rchk(cmo_pkg::MIRROR_ADDR, 32'h2A, 1'b0);
    rchk(8'h10, 32'h00, 1'b1);
    // edges made by invert alone while the core is off
    w(cmo_pkg::EDGE_EN_ADDR, 32'h02);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h14);
    cyc(8);
    rchk(cmo_pkg::MAIN_CTRL_ADDR, 32'h54, 1'b0);
    rchk(cmo_pkg::EVENT_ADDR, 32'h01, 1'b0);
    w(cmo_pkg::EVENT_ADDR, 32'h01);
    rchk(cmo_pkg::EVENT_ADDR, 32'h00, 1'b0);
    // filtered rise lands on the same edge as a clear, which must lose
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h0C);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h1C);
    w(cmo_pkg::EVENT_ADDR, 32'h01);
    rchk(cmo_pkg::EVENT_ADDR, 32'h01, 1'b0);
    w(cmo_pkg::EVENT_ADDR, 32'h01);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h04);
    cyc(8);
    rchk(cmo_pkg::EVENT_ADDR, 32'h00, 1'b0);
    w(cmo_pkg::EDGE_EN_ADDR, 32'h01);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h14);
    cyc(8);
    rchk(cmo_pkg::EVENT_ADDR, 32'h00, 1'b0);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h04);
    cyc(8);
    rchk(cmo_pkg::EVENT_ADDR, 32'h01, 1'b0);
    w(cmo_pkg::EVENT_ADDR, 32'h01);
    // both edges enabled: the invert toggle to high while disabled raises the flag
    w(cmo_pkg::EDGE_EN_ADDR, 32'h03);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h14);
    cyc(4);
    rchk(cmo_pkg::EVENT_ADDR, 32'h01, 1'b0);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h04);
    w(cmo_pkg::EVENT_ADDR, 32'h01);
    rchk(cmo_pkg::EVENT_ADDR, 32'h00, 1'b0);
    level <= 1'b1;
    w(cmo_pkg::EDGE_EN_ADDR, 32'h02);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h84);
    cyc(8);
    rchk(cmo_pkg::EVENT_ADDR, 32'h01, 1'b0);
    rchk(cmo_pkg::MAIN_CTRL_ADDR, 32'hC4, 1'b0);
    rchk(cmo_pkg::MIRROR_ADDR, 32'h2B, 1'b0);
    @(negedge clk);
    chk("pinOut", 32'h1, 32'(pinOut));
    chk("flag", 32'h1, 32'(flag));
    @(posedge clk);
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h94);
    cyc(8);
    rchk(cmo_pkg::MAIN_CTRL_ADDR, 32'h94, 1'b0);
    @(negedge clk);
    chk("pinOut", 32'h0, 32'(pinOut));
    @(posedge clk);
    shares <= 1'b1;
    opampOn <= 1'b1;
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'hA6);
    @(negedge clk);
    chk("analogCtrl", 32'h1F, 32'(analogCtrl));
    @(posedge clk);
    opampOn <= 1'b0;
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h26);
    @(negedge clk);
    chk("analogCtrl", 32'h06, 32'(analogCtrl));
    @(posedge clk);
    // one-cycle glitch, first unfiltered then filtered
    level <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      w(cmo_pkg::MAIN_CTRL_ADDR, 32'h84 | 32'(f << 3));
      cyc(8);
      hi = 0;
      level <= 1'b1;
      @(posedge clk);
      level <= 1'b0;
      repeat (12) begin
        @(negedge clk);
        hi += int'(pinOut === 1'b1);
      end
      @(posedge clk);
      chk("highCycles", 32'(f ? cmo_pkg::FILTER_HOLD_CYC : 1), 32'(hi));
    end
    // sync latch follows only falling timer edges
    timerRun <= 1'b1;
    w(cmo_pkg::MAIN_CTRL_ADDR, 32'h85);
    cyc(24);
    timerRun <= 1'b0;
    level <= 1'b1;
    cyc(12);
    @(negedge clk);
    chk("pinOut", 32'h0, 32'(pinOut));
    chk("gate", 32'h0, 32'(gate));
    rises = 0;
    adv = 0;
    prevClk = tclk;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      timerRun <= (i < 24);
      @(negedge clk);
      rises += int'(tclk === 1'b1 && prevClk === 1'b0);
      prevClk = tclk;
      adv += int'(tAdv === 1'b1);
    end
    chk("pinOut", 32'h1, 32'(pinOut));
    chk("gate", 32'h1, 32'(gate));
    chk("advances", 32'(rises), 32'(adv));
    tally_and_finish();
  end
endmodule
